// File: logic/dsr_pkg.sv
// package: status word layout, flag commands and device-side carrier types
package dsr_pkg;
    localparam int          STAT_W        = 16;
    localparam int          DEVCODE_W     = 6;
    // status bit positions, bit 0 is the most significant accumulator bit
    localparam int          POS_OFF_LINE  = 0;
    localparam int          POS_HOME_TRK  = 1;
    localparam int          POS_HEAD_LD   = 2;
    localparam int          POS_RSV_LO    = 3;
    localparam int          POS_RSV_HI    = 5;
    localparam int          POS_WPROT     = 6;
    localparam int          POS_UNIT      = 7;
    localparam int          POS_NR_HIST   = 8;
    localparam int          POS_SPARE9    = 9;
    localparam int          POS_BAD_CMD   = 10;
    localparam int          POS_SECT_MIS  = 11;
    localparam int          POS_CHK_MIS   = 12;
    localparam int          POS_CH_LATE   = 13;
    localparam int          POS_XPORT_FLT = 14;
    localparam int          POS_SUMMARY   = 15;
    localparam logic [2:0]  RSV_VALUE     = 3'h0;
    localparam logic        SPARE9_VALUE  = 1'h0;
    localparam logic [15:0] STAT_RESET    = 16'h0000;
    localparam logic [4:0]  ERR_RESET     = 5'h00;

    typedef enum logic [1:0] {
        DSR_FN_NONE  = 2'b00,
        DSR_FN_START = 2'b01,
        DSR_FN_CLEAR = 2'b10,
        DSR_FN_PULSE = 2'b11
    } dsr_flag_fn_e;

    // drive condition levels, arriving from the transport pins
    typedef struct packed {
        logic off_line;
        logic home_track;
        logic head_loaded;
        logic write_prot;
        logic unit;
        logic xport_fault;
    } dsr_drive_s;

    // one-cycle error and data-read events from the controller datapath
    typedef struct packed {
        logic bad_command;
        logic sector_mismatch;
        logic check_mismatch;
        logic channel_late;
        logic data_read;
    } dsr_event_s;
endpackage

// File: logic/dsr_sync2.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module dsr_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } dsr_sync_s;

    dsr_sync_s st_r;
    dsr_sync_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (clk_en) begin
            st_nxt.meta   = async_in;
            st_nxt.stable = st_r.meta;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;
endmodule

// File: logic/dsr_status.sv
// diskette status word, flag commands and device-code jumpers
`timescale 1ns/1ps
module dsr_status
    import dsr_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    input  wire logic [DEVCODE_W-1:0] code_jumper_in,
    input  wire logic [DEVCODE_W-1:0] io_dev_sel,
    input  wire logic                 status_input_instr,
    input  wire logic                 flag_strobe,
    input  wire dsr_flag_fn_e         flag_fn,
    input  wire dsr_drive_s           drive_pins,
    input  wire dsr_event_s           ctl_events,
    input  wire logic                 op_complete,
    output logic [STAT_W-1:0]         cpu_work_reg,
    output logic                      cpu_work_valid,
    output logic [DEVCODE_W-1:0]      device_code,
    output logic                      busy,
    output logic                      done,
    output logic                      op_launch,
    output logic                      xfer_halt
);
    typedef struct packed {
        logic [DEVCODE_W-1:0] dev_code;
        logic                 code_taken;
        logic [1:0]           jmp_settle;
        logic                 not_ready_history;
        logic                 bad_command_flag;
        logic                 sector_mismatch_flag;
        logic                 check_mismatch_flag;
        logic                 channel_late_flag;
        logic                 data_seen;
        logic                 busy;
        logic                 done;
        logic                 launch;
        logic                 halt;
        logic [STAT_W-1:0]    word;
        logic                 word_valid;
    } dsr_state_s;

    dsr_state_s  st_r;
    dsr_state_s  st_nxt;
    dsr_drive_s  drv;
    logic [DEVCODE_W-1:0] jmp;
    logic [STAT_W-1:0]    live_word;
    logic                 any_err;
    logic                 addressed;

    // transport levels and jumpers are off-domain, so two flops first
    dsr_sync2 #(.WIDTH($bits(dsr_drive_s))) u_sync_drive (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .async_in (drive_pins),
        .sync_out (drv)
    );
    dsr_sync2 #(.WIDTH(DEVCODE_W)) u_sync_jmp (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .async_in (code_jumper_in),
        .sync_out (jmp)
    );

    assign addressed = (io_dev_sel == st_r.dev_code) && st_r.code_taken;
    // write fault comes live from the transport, so clear cannot remove it
    assign any_err   = st_r.bad_command_flag | st_r.sector_mismatch_flag | st_r.check_mismatch_flag
                     | st_r.channel_late_flag | drv.xport_fault;

    // bit 0 is the leftmost accumulator bit, hence index STAT_W-1-pos
    always_comb begin
        live_word = STAT_RESET;
        live_word[STAT_W-1-POS_OFF_LINE]  = drv.off_line;
        live_word[STAT_W-1-POS_HOME_TRK]  = drv.home_track;
        live_word[STAT_W-1-POS_HEAD_LD]   = drv.head_loaded;
        live_word[STAT_W-1-POS_RSV_LO -: 3] = RSV_VALUE;
        live_word[STAT_W-1-POS_WPROT]     = drv.write_prot;
        live_word[STAT_W-1-POS_UNIT]      = drv.unit;
        live_word[STAT_W-1-POS_NR_HIST]   = st_r.not_ready_history | drv.off_line;
        live_word[STAT_W-1-POS_SPARE9]    = SPARE9_VALUE;
        live_word[STAT_W-1-POS_BAD_CMD]   = st_r.bad_command_flag;
        live_word[STAT_W-1-POS_SECT_MIS]  = st_r.sector_mismatch_flag;
        live_word[STAT_W-1-POS_CHK_MIS]   = st_r.check_mismatch_flag;
        live_word[STAT_W-1-POS_CH_LATE]   = st_r.channel_late_flag;
        live_word[STAT_W-1-POS_XPORT_FLT] = drv.xport_fault;
        live_word[STAT_W-1-POS_SUMMARY]   = any_err | (st_r.done & ~st_r.data_seen);
    end

    always_comb begin
        st_nxt        = st_r;
        st_nxt.launch = 1'b0;
        st_nxt.halt   = 1'b0;
        st_nxt.word_valid = 1'b0;
        // wait out both synchroniser flops, else the code latches as zero
        if (!st_r.code_taken) begin
            st_nxt.jmp_settle = {st_r.jmp_settle[0], 1'b1};
            if (st_r.jmp_settle[1]) begin
                st_nxt.dev_code   = jmp;
                st_nxt.code_taken = 1'b1;
            end
        end
        // datapath events set flags; flags hold until start or clear, data_seen until start only
        if (ctl_events.bad_command)     st_nxt.bad_command_flag     = 1'b1;
        if (ctl_events.sector_mismatch) st_nxt.sector_mismatch_flag = 1'b1;
        if (ctl_events.check_mismatch)  st_nxt.check_mismatch_flag  = 1'b1;
        if (ctl_events.channel_late)    st_nxt.channel_late_flag    = 1'b1;
        if (ctl_events.data_read)       st_nxt.data_seen            = 1'b1;
        if (drv.off_line)               st_nxt.not_ready_history    = 1'b1;
        if (op_complete && st_r.busy) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
        end
        if (status_input_instr && addressed) begin
            st_nxt.word       = live_word;
            st_nxt.word_valid = 1'b1;
        end
        if (flag_strobe && addressed) begin
            case (flag_fn)
                DSR_FN_START: begin
                    st_nxt.busy   = 1'b1;
                    st_nxt.done   = 1'b0;
                    st_nxt.launch = 1'b1;
                    st_nxt.data_seen = ctl_events.data_read;
                    st_nxt.bad_command_flag     = ctl_events.bad_command;
                    st_nxt.sector_mismatch_flag = ctl_events.sector_mismatch;
                    st_nxt.check_mismatch_flag  = ctl_events.check_mismatch;
                    st_nxt.channel_late_flag    = ctl_events.channel_late;
                    st_nxt.not_ready_history    = drv.off_line;
                end
                DSR_FN_CLEAR: begin
                    st_nxt.busy   = 1'b0;
                    st_nxt.done   = 1'b0;
                    st_nxt.halt   = 1'b1;
                    st_nxt.bad_command_flag     = ctl_events.bad_command;
                    st_nxt.sector_mismatch_flag = ctl_events.sector_mismatch;
                    st_nxt.check_mismatch_flag  = ctl_events.check_mismatch;
                    st_nxt.channel_late_flag    = ctl_events.channel_late;
                    st_nxt.not_ready_history    = drv.off_line;
                end
                DSR_FN_PULSE: begin
                    // completion in the same cycle wins over the pulse
                    st_nxt.done = op_complete & st_r.busy;
                end
                default: begin
                end
            endcase
        end
        if (!clk_en) begin
            st_nxt = st_r;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cpu_work_reg   = st_r.word;
    assign cpu_work_valid = st_r.word_valid;
    assign device_code    = st_r.dev_code;
    assign busy           = st_r.busy;
    assign done           = st_r.done;
    assign op_launch      = st_r.launch;
    assign xfer_halt      = st_r.halt;

    a_read_word_load: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && status_input_instr && addressed |=> cpu_work_valid && cpu_work_reg == $past(live_word))
        else $error("status word not returned");
    a_off_line_bit: assert property (@(posedge core_clk) disable iff (!reset_n)
        cpu_work_valid |-> cpu_work_reg[STAT_W-1-POS_OFF_LINE] == $past(drv.off_line))
        else $error("off line bit wrong");
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        cpu_work_valid |-> cpu_work_reg[STAT_W-1-POS_RSV_LO -: 3] == RSV_VALUE)
        else $error("reserved bits not fixed");
    a_history_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && drv.off_line && !(flag_strobe && addressed && flag_fn != DSR_FN_PULSE)
        |=> st_r.not_ready_history)
        else $error("not ready history lost");
    a_bad_cmd_set: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && ctl_events.bad_command |=> st_r.bad_command_flag)
        else $error("illegal command flag not set");
    a_summary_or: assert property (@(posedge core_clk) disable iff (!reset_n)
        cpu_work_valid && $past(any_err) |-> cpu_work_reg[STAT_W-1-POS_SUMMARY])
        else $error("summary misses an error");
    a_start_effect: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && flag_strobe && addressed && flag_fn == DSR_FN_START
        |=> busy && !done && op_launch ##1 !op_launch)
        else $error("start did not take effect");
    a_clear_effect: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && flag_strobe && addressed && flag_fn == DSR_FN_CLEAR && !ctl_events.channel_late
        |=> !busy && !done && xfer_halt && !st_r.channel_late_flag)
        else $error("clear did not take effect");
    a_pulse_done_only: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && flag_strobe && addressed && flag_fn == DSR_FN_PULSE && !op_complete
        |=> !done && busy == $past(busy) && !op_launch)
        else $error("pulse touched more than done");
    a_done_set_wins: assert property (@(posedge core_clk) disable iff (!reset_n)
        clk_en && op_complete && busy && !(flag_strobe && addressed && flag_fn != DSR_FN_PULSE) |=> done)
        else $error("completion did not set done");
    a_code_from_jumpers: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(st_r.code_taken) |-> device_code == $past(jmp))
        else $error("device code not taken from jumpers");
    a_code_held: assert property (@(posedge core_clk) disable iff (!reset_n)
        st_r.code_taken |=> device_code == $past(device_code))
        else $error("device code changed after capture");
    a_errors_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        st_r.check_mismatch_flag && !(flag_strobe && addressed && flag_fn != DSR_FN_PULSE)
        |=> st_r.check_mismatch_flag)
        else $error("error flag dropped early");
endmodule

// File: sim/dsr_host_model.sv
// host cpu model: issues status reads and flag commands as I/O instructions
`timescale 1ns/1ps
module dsr_host_model
    import dsr_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic [STAT_W-1:0]    cpu_work_reg,
    input  wire logic                 cpu_work_valid,
    output logic                      status_input_instr,
    output logic                      flag_strobe,
    output dsr_flag_fn_e              flag_fn,
    output logic [DEVCODE_W-1:0]      io_dev_sel
);
    initial begin
        status_input_instr = 1'b0;
        flag_strobe        = 1'b0;
        flag_fn            = DSR_FN_NONE;
        io_dev_sel         = 6'h00;
    end
    // one instruction: optional read, then its flag function
    task automatic io_instr(input logic rd, input dsr_flag_fn_e fn, input logic [5:0] sel,
                            output logic [15:0] word, output logic vld);
        @(negedge core_clk);
        status_input_instr = rd;
        flag_strobe        = (fn != DSR_FN_NONE);
        flag_fn            = fn;
        io_dev_sel         = sel;
        @(negedge core_clk);
        word               = cpu_work_reg;
        vld                = cpu_work_valid;
        status_input_instr = 1'b0;
        flag_strobe        = 1'b0;
        flag_fn            = DSR_FN_NONE;
        // released select shows the inverse, so a stale code never matches
        io_dev_sel         = ~sel;
    endtask
endmodule

// File: sim/tb.sv
// self-checking bench: status reads and flag commands through the host model
`timescale 1ns/1ps
module tb;
    import dsr_pkg::*;
    localparam logic [5:0]  CODE = 6'h1B;
    // status bit k sits at word position 15-k
    localparam logic [15:0] PIN_EXP [6] = '{16'h0003, 16'h0100, 16'h0200, 16'h2000, 16'h4000, 16'h8080};
    logic                   core_clk = 1'b0;
    logic                   reset_n = 1'b0;
    logic                   op_complete = 1'b0;
    logic                   clk_en = 1'b1;
    dsr_drive_s             drive_pins = 6'h00;
    dsr_event_s             ctl_events = 5'h00;
    logic [STAT_W-1:0]      cpu_work_reg;
    logic                   cpu_work_valid, busy, done, op_launch, xfer_halt;
    logic [DEVCODE_W-1:0]   device_code, io_dev_sel;
    logic                   status_input_instr, flag_strobe;
    dsr_flag_fn_e           flag_fn;
    logic [15:0]            w, acc;
    logic                   v;
    int                     num_errors = 0;
    int                     tests_run = 0;
    wire  [15:0]            flg = {12'h000, busy, done, op_launch, xfer_halt};
    always #20 core_clk = ~core_clk;
    dsr_status dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .code_jumper_in(CODE),
        .io_dev_sel(io_dev_sel), .status_input_instr(status_input_instr), .flag_strobe(flag_strobe),
        .flag_fn(flag_fn), .drive_pins(drive_pins), .ctl_events(ctl_events), .op_complete(op_complete),
        .cpu_work_reg(cpu_work_reg), .cpu_work_valid(cpu_work_valid), .device_code(device_code),
        .busy(busy), .done(done), .op_launch(op_launch), .xfer_halt(xfer_halt));
    dsr_host_model host (.core_clk(core_clk), .cpu_work_reg(cpu_work_reg), .cpu_work_valid(cpu_work_valid),
        .status_input_instr(status_input_instr), .flag_strobe(flag_strobe), .flag_fn(flag_fn),
        .io_dev_sel(io_dev_sel));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [15:0] exp);
        host.io_instr(1'b1, DSR_FN_NONE, CODE, w, v);
        chk("valid", {15'h0000, v}, 16'h0001);
        chk("status", w, exp);
    endtask
    task automatic cmd(input dsr_flag_fn_e fn);
        host.io_instr(1'b0, fn, CODE, w, v);
    endtask
    // one-cycle datapath pulse
    task automatic ev(input logic [4:0] e, input logic oc);
        @(negedge core_clk);
        ctl_events  = e;
        op_complete = oc;
        @(negedge core_clk);
        ctl_events  = 5'h00;
        op_complete = 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge core_clk);
        reset_n = 1'b1;
        // jumpers need three edges to reach the code
        repeat (4) @(negedge core_clk);
        chk("devcode", {10'h000, device_code}, {10'h000, CODE});
        for (int i = 0; i < 6; i++) begin
            drive_pins = 6'h01 << i;
            repeat (3) @(negedge core_clk);
            rd(PIN_EXP[i]);
        end
        drive_pins = 6'h00;
        repeat (3) @(negedge core_clk);
        rd(16'h0080);
        cmd(DSR_FN_CLEAR);
        chk("flags", flg, 16'h0001);
        rd(16'h0000);
        cmd(DSR_FN_START);
        chk("flags", flg, 16'h000A);
        acc = 16'h0001;
        for (int i = 0; i < 4; i++) begin
            ev(5'h10 >> i, 1'b0);
            acc = acc | (16'h0020 >> i);
            rd(acc);
        end
        ev(5'h00, 1'b1);
        chk("flags", flg, 16'h0004);
        host.io_instr(1'b1, DSR_FN_PULSE, CODE, w, v);
        chk("status", w, acc);
        chk("flags", flg, 16'h0000);
        rd(acc);
        host.io_instr(1'b1, DSR_FN_START, CODE, w, v);
        chk("status", w, acc);
        rd(16'h0000);
        ev(5'h00, 1'b1);
        rd(16'h0001);
        cmd(DSR_FN_START);
        ev(5'h01, 1'b0);
        ev(5'h00, 1'b1);
        rd(16'h0000);
        cmd(DSR_FN_START);
        ev(5'h04, 1'b0);
        cmd(DSR_FN_CLEAR);
        chk("flags", flg, 16'h0001);
        rd(16'h0000);
        host.io_instr(1'b1, DSR_FN_NONE, ~CODE, w, v);
        chk("refused", {15'h0000, v}, 16'h0000);
        // clock enable low: the instruction must leave no trace
        clk_en = 1'b0;
        host.io_instr(1'b1, DSR_FN_START, CODE, w, v);
        clk_en = 1'b1;
        chk("frozen", {15'h0000, v}, 16'h0000);
        chk("flags", flg, 16'h0000);
        // mid-run reset drops latched errors and retakes the code
        ev(5'h10, 1'b0);
        reset_n = 1'b0;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge core_clk);
        chk("devcode", {10'h000, device_code}, {10'h000, CODE});
        rd(16'h0000);
        drive_pins = 6'h01;
        repeat (3) @(negedge core_clk);
        cmd(DSR_FN_CLEAR);
        rd(16'h0003);
        end_of_test();
    end
    // hang guard: far beyond the roughly 120 cycles the sequence needs
    initial begin
        #1000000;
        num_errors++;
        end_of_test();
    end
endmodule
